// ===== ppc_pkg.sv
/*
  ppc_pkg: register map, field layout and reset values for the
  seven-pin port control block.
  Assumes an AXI4-Lite slave with 32-bit data, one register per word.
*/
package ppc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned ADDR_W    = 5;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PIN_DATA_OFS   = 5'h00;
  localparam logic [ADDR_W-1:0] PIN_DIR_OFS    = 5'h04;
  localparam logic [ADDR_W-1:0] PULLUP_OFS     = 5'h08;
  localparam logic [ADDR_W-1:0] SLEW_OFS       = 5'h0C;
  localparam logic [ADDR_W-1:0] DRIVE_OFS      = 5'h10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PIN_COUNT-1:0] PIN_DATA_RST = 7'h00;
  localparam logic [PIN_COUNT-1:0] PIN_DIR_RST  = 7'h00;
  localparam logic [PIN_COUNT-1:0] PULLUP_RST   = 7'h00;
  localparam logic [PIN_COUNT-1:0] SLEW_RST     = 7'h00;
  localparam logic [PIN_COUNT-1:0] DRIVE_RST    = 7'h00;

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [PIN_COUNT-1:0] ppc_pins_type;

endpackage : ppc_pkg

// ===== ppc_sync_if.sv
/*
  ppc_sync_if: carries the raw pad levels into the synchroniser and the
  settled levels back to the port control top.
  Assumes a single clock domain on the receiving side.
*/
`timescale 1ns/1ns
`default_nettype none
interface ppc_sync_if;
  import ppc_pkg::*;
  ppc_pins_type raw;
  ppc_pins_type stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface : ppc_sync_if
`default_nettype wire

// ===== ppc_pin_sync.sv
/*
  ppc_pin_sync: three-stage synchroniser for the seven pad inputs; a new
  level is accepted only once stages two and three agree.
  Assumes pad levels are asynchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ppc_pin_sync (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  ppc_sync_if.sync      pins
);
  import ppc_pkg::*;

  ppc_pins_type s1_q, s2_q, s3_q, st_q;
  ppc_pins_type s1_d, s2_d, s3_d, st_d;

  // stage one feeds only stage two
  always_comb begin
    s1_d = pins.raw;
    s2_d = s1_q;
    s3_d = s2_q;
    // take stage two where stages two and three agree, else hold, filters glitches
    st_d = (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= PIN_DATA_RST;
      s2_q <= PIN_DATA_RST;
      s3_q <= PIN_DATA_RST;
      st_q <= PIN_DATA_RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      st_q <= st_d;
    end
  end

  assign pins.stable = st_q;

endmodule : ppc_pin_sync
`default_nettype wire

// ===== ppc_port_ctrl.sv
/*
  ppc_port_ctrl: seven-pin general-purpose port with per-pin pullup,
  slew-rate and drive-strength control, registers over AXI4-Lite.
  Assumes pad cells that take output, output enable, pullup, slew and
  drive controls per pin, and a single 125 MHz clock.
*/
// Contract
// - pullup bit 1 enables pin pullup
// - output pins keep pullup off always
// - slew bit 1 enables output slew limiting
// - input pins ignore the slew bit
// - drive bit 0 low, 1 high
// - direction 0 input, 1 drives output
// - reset leaves pins undriven, pullups off
`timescale 1ns/1ns
`default_nettype none
module ppc_port_ctrl (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ppc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ppc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire ppc_pkg::ppc_pins_type      pin_in,
  output var  ppc_pkg::ppc_pins_type      pin_out,
  output var  ppc_pkg::ppc_pins_type      pin_oe,
  output var  ppc_pkg::ppc_pins_type      pin_pullup,
  output var  ppc_pkg::ppc_pins_type      pin_slew,
  output var  ppc_pkg::ppc_pins_type      pin_drive_high
);
  import ppc_pkg::*;

  // ----------------------------------------------------------------
  // pad input synchroniser
  // ----------------------------------------------------------------
  ppc_sync_if sync_bus ();
  assign sync_bus.raw = pin_in;

  ppc_pin_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (sync_bus)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  ppc_pins_type data_q, dir_q, pullup_enable_q, slew_rate_enable_q, drive_strength_select_q;
  ppc_pins_type data_d, dir_d, pullup_enable_d, slew_rate_enable_d, drive_strength_select_d;

  logic              aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic              aw_held_d, w_held_d, bvalid_d, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
  logic              wlane0_q, wlane0_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  // readies kept in flops so no bus output is combinational
  logic              awready_q, wready_q, arready_q;
  logic              awready_d, wready_d, arready_d;

  ppc_pins_type out_q, oe_q, pu_q, slew_q, drv_q;
  ppc_pins_type out_d, oe_d, pu_d, slew_d, drv_d;

  // true when the byte address names one of the five registers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == PIN_DATA_OFS) || (a == PIN_DIR_OFS) || (a == PULLUP_OFS)
            || (a == SLEW_OFS) || (a == DRIVE_OFS);
  endfunction : addr_hit

  // pad-facing view of the data register: input pins show the pin
  function automatic ppc_pins_type data_view(input ppc_pins_type dir,
                                             input ppc_pins_type dat,
                                             input ppc_pins_type pad);
    data_view = (dir & dat) | (~dir & pad);
  endfunction : data_view

  logic do_write;
  logic do_read;

  // ----------------------------------------------------------------
  // write channel: address and data accepted in either order
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wlane0_d  = wlane0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wlane0_d = s_axi_wstrb[0];
    end
    do_write = aw_held_q && w_held_q && !bvalid_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // ----------------------------------------------------------------
  // register update; bit 7 of each byte is never stored
  // ----------------------------------------------------------------
  always_comb begin
    data_d                  = data_q;
    dir_d                   = dir_q;
    pullup_enable_d         = pullup_enable_q;
    slew_rate_enable_d      = slew_rate_enable_q;
    drive_strength_select_d = drive_strength_select_q;
    if (do_write && wlane0_q) begin
      case (awaddr_q)
        PIN_DATA_OFS: data_d                  = wdata_q[PIN_COUNT-1:0];
        PIN_DIR_OFS:  dir_d                   = wdata_q[PIN_COUNT-1:0];
        PULLUP_OFS:   pullup_enable_d         = wdata_q[PIN_COUNT-1:0];
        SLEW_OFS:     slew_rate_enable_d      = wdata_q[PIN_COUNT-1:0];
        DRIVE_OFS:    drive_strength_select_d = wdata_q[PIN_COUNT-1:0];
        default:      data_d                  = data_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel: one read at a time, answer one cycle after arvalid
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    do_read  = s_axi_arvalid && !rvalid_q;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d  = 32'h0000_0000; // upper bits and bit 7 read zero
      case (s_axi_araddr)
        PIN_DATA_OFS: rdata_d[PIN_COUNT-1:0] = data_view(dir_q, data_q, sync_bus.stable);
        PIN_DIR_OFS:  rdata_d[PIN_COUNT-1:0] = dir_q;
        PULLUP_OFS:   rdata_d[PIN_COUNT-1:0] = pullup_enable_q;
        SLEW_OFS:     rdata_d[PIN_COUNT-1:0] = slew_rate_enable_q;
        DRIVE_OFS:    rdata_d[PIN_COUNT-1:0] = drive_strength_select_q;
        default:      rdata_d                = 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // ----------------------------------------------------------------
  // pad controls, qualified by direction except drive strength
  // ----------------------------------------------------------------
  always_comb begin
    out_d  = data_q & dir_q;                    // output level only where driven
    oe_d   = dir_q;
    pu_d   = pullup_enable_q & ~dir_q;
    slew_d = slew_rate_enable_q & dir_q;
    drv_d  = drive_strength_select_q;
  end

  // all state but the readies clears at reset, so no pin is driven or pulled up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q                  <= PIN_DATA_RST;
      dir_q                   <= PIN_DIR_RST;
      pullup_enable_q         <= PULLUP_RST;
      slew_rate_enable_q      <= SLEW_RST;
      drive_strength_select_q <= DRIVE_RST;
      aw_held_q               <= 1'b0;
      w_held_q                <= 1'b0;
      bvalid_q                <= 1'b0;
      rvalid_q                <= 1'b0;
      awaddr_q                <= '0;
      wdata_q                 <= 32'h0000_0000;
      wlane0_q                <= 1'b0;
      bresp_q                 <= RESP_OKAY;
      rresp_q                 <= RESP_OKAY;
      rdata_q                 <= 32'h0000_0000;
      awready_q               <= 1'b1;
      wready_q                <= 1'b1;
      arready_q               <= 1'b1;
      out_q                   <= PIN_DATA_RST;
      oe_q                    <= PIN_DIR_RST;
      pu_q                    <= PULLUP_RST;
      slew_q                  <= SLEW_RST;
      drv_q                   <= DRIVE_RST;
    end else begin
      data_q                  <= data_d;
      dir_q                   <= dir_d;
      pullup_enable_q         <= pullup_enable_d;
      slew_rate_enable_q      <= slew_rate_enable_d;
      drive_strength_select_q <= drive_strength_select_d;
      aw_held_q               <= aw_held_d;
      w_held_q                <= w_held_d;
      bvalid_q                <= bvalid_d;
      rvalid_q                <= rvalid_d;
      awaddr_q                <= awaddr_d;
      wdata_q                 <= wdata_d;
      wlane0_q                <= wlane0_d;
      bresp_q                 <= bresp_d;
      rresp_q                 <= rresp_d;
      rdata_q                 <= rdata_d;
      awready_q               <= awready_d;
      wready_q                <= wready_d;
      arready_q               <= arready_d;
      out_q                   <= out_d;
      oe_q                    <= oe_d;
      pu_q                    <= pu_d;
      slew_q                  <= slew_d;
      drv_q                   <= drv_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign pin_out        = out_q;
  assign pin_oe         = oe_q;
  assign pin_pullup     = pu_q;
  assign pin_slew       = slew_q;
  assign pin_drive_high = drv_q;

endmodule : ppc_port_ctrl
`default_nettype wire

// ===== ppc_props.sv
/*
  ppc_props: port-level assertions for the seven-pin port control.
  Assumes it is bound onto ppc_port_ctrl, one clock, sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ppc_props (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire ppc_pkg::ppc_pins_type pin_out,
  input wire ppc_pkg::ppc_pins_type pin_oe,
  input wire ppc_pkg::ppc_pins_type pin_pullup,
  input wire ppc_pkg::ppc_pins_type pin_slew
);
  import ppc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // pad gating and reset state
  // ----------------------------------------------------------------
  pullup_gate_a: assert property ((pin_pullup & pin_oe) == 7'h00)
    else $error("pullup on a driven pin");
  slew_gate_a: assert property ((pin_slew & ~pin_oe) == 7'h00)
    else $error("slew limit on an input pin");
  out_gate_a: assert property ((pin_out & ~pin_oe) == 7'h00)
    else $error("level on an undriven pin");
  reset_quiet_a: assert property ($rose(aresetn) |-> (pin_oe | pin_pullup) == 7'h00)
    else $error("pads active after reset");
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  top_bits_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
    else $error("upper read bits not zero");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
endmodule : ppc_props
bind ppc_port_ctrl ppc_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out, .pin_oe,
  .pin_pullup, .pin_slew);
`default_nettype wire

// ===== ppc_board_model.sv
/*
  ppc_board_model: board side of the seven pins.
  Assumes weak board pull-downs, overpowered by the internal pullups.
*/
`timescale 1ns/1ns
`default_nettype none
module ppc_board_model (
  input wire ppc_pkg::ppc_pins_type pin_out,
  input wire ppc_pkg::ppc_pins_type pin_oe,
  input wire ppc_pkg::ppc_pins_type pin_pullup,
  output var ppc_pkg::ppc_pins_type pin_in
);
  // ----------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------
  // floating pins fall to the pull-down level, never hold a stale value
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup);
  end
endmodule : ppc_board_model
`default_nettype wire

// ===== tb_ppc_port_ctrl.sv
/*
  tb_ppc_port_ctrl: register-level tests of the seven-pin port control.
  Assumes the board model on the pins and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_ppc_port_ctrl;
  import ppc_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  ppc_pins_type      pin_in, pin_out, pin_oe, pin_pu, pin_sl, pin_dh;
  int                err_total = 0, n_tests = 0, cyc = 0;
  // edges the master waits before raising bready or rready
  int                ready_lag = 0;
  // 125 MHz
  always #4 aclk = ~aclk;
  ppc_port_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .pin_slew(pin_sl), .pin_drive_high(pin_dh));
  ppc_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .pin_in(pin_in));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int k = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= (ready_lag == 0);
    // waits as long as it takes; only the watchdog ends a hang
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      k++;
      if (k >= ready_lag) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er,
                     input string nm);
    int k = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= (ready_lag == 0);
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      k++;
      if (k >= ready_lag) rready <= 1'b1;
    end
    rready <= 1'b0;
    chk(nm, rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask : rdc
  // pad outputs settle one cycle after the write response
  task automatic pads(input ppc_pins_type eo, ep, es, ed);
    repeat (2) @(posedge aclk);
    chk("pin_oe", 32'(pin_oe), 32'(eo));
    chk("pin_pullup", 32'(pin_pu), 32'(ep));
    chk("pin_slew", 32'(pin_sl), 32'(es));
    chk("pin_drive_high", 32'(pin_dh), 32'(ed));
  endtask : pads
  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // watchdog: the whole sequence needs well under 1500 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst();
    pads(7'h00, 7'h00, 7'h00, 7'h00);
    for (int i = 0; i < 5; i++) rdc(5'(4 * i), 32'h0, RESP_OKAY, "reset value");
    wr(PULLUP_OFS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rdc(PULLUP_OFS, 32'h7F, RESP_OKAY, "pullup");
    pads(7'h00, 7'h7F, 7'h00, 7'h00);
    wr(PIN_DIR_OFS, 32'h0F, 4'hF, RESP_OKAY);
    wr(SLEW_OFS, 32'hFF, 4'hF, RESP_OKAY);
    wr(DRIVE_OFS, 32'h55, 4'hF, RESP_OKAY);
    wr(PIN_DATA_OFS, 32'h05, 4'hF, RESP_OKAY);
    pads(7'h0F, 7'h70, 7'h0F, 7'h55);
    chk("pin_out", 32'(pin_out), 32'h05);
    // let the pin synchroniser catch up before reading levels
    repeat (8) @(posedge aclk);
    rdc(PIN_DATA_OFS, 32'h75, RESP_OKAY, "pin data");
    // late ready on both answers: response and read data must wait
    ready_lag = 3;
    wr(DRIVE_OFS, 32'h00, 4'h0, RESP_OKAY);
    rdc(DRIVE_OFS, 32'h55, RESP_OKAY, "masked write");
    ready_lag = 0;
    wr(5'h14, 32'h7F, 4'hF, RESP_SLVERR);
    rdc(5'h14, 32'h0, RESP_SLVERR, "unmapped");
    wr(SLEW_OFS, 32'h80, 4'hF, RESP_OKAY);
    rdc(SLEW_OFS, 32'h00, RESP_OKAY, "slew top bit");
    wr(PIN_DIR_OFS, 32'h70, 4'hF, RESP_OKAY);
    pads(7'h70, 7'h0F, 7'h00, 7'h55);
    chk("pin_out", 32'(pin_out), 32'h00);
    // pullups off: input levels must fall back through the synchroniser
    wr(PULLUP_OFS, 32'h00, 4'hF, RESP_OKAY);
    repeat (8) @(posedge aclk);
    rdc(PIN_DATA_OFS, 32'h00, RESP_OKAY, "pin data low");
    rst();
    pads(7'h00, 7'h00, 7'h00, 7'h00);
    rdc(PULLUP_OFS, 32'h0, RESP_OKAY, "pullup after reset");
    wrap_up();
  end
endmodule : tb_ppc_port_ctrl
`default_nettype wire
